// [rtl/tws_pkg.sv]
package tws_pkg;

  // ************************************************************
  // slave address, range and width constants
  // ************************************************************
  localparam logic [3:0]  MEM_ID        = 4'ha;
  localparam logic [3:0]  REG_ID        = 4'hd;
  localparam logic [7:0]  REG_TOP       = 8'h18;
  localparam logic [7:0]  REG_ADDR_RST  = 8'h00;
  localparam logic [15:0] MEM_ADDR_RST  = 16'h0000;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  localparam int          MEM_AW_DEF    = 15;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_SLAVE   = 6'h02,
    ST_ACK_OUT = 6'h04,
    ST_RX      = 6'h08,
    ST_TX      = 6'h10,
    ST_ACK_IN  = 6'h20
  } tws_state_e;

  typedef enum logic [2:0] {
    PH_HI   = 3'h1,
    PH_LO   = 3'h2,
    PH_DATA = 3'h4
  } tws_phase_e;

  typedef struct packed {
    logic        reg_tgt;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } tws_acc_s;

  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       trip;
    logic [1:0] sel;
  } tws_pins_s;

endpackage

// [rtl/tws_slave.sv]
// Function
// - start is sda fall while scl high
// - start aborts everything, expects slave address
// - supply trip aborts transfer, needs new start
// - stop is sda rise while scl high
// - bits sampled while scl high
// - transmitter releases after 8th bit, receiver acks
// - no ack in slot aborts operation
// - reads continue while master acks
// - first byte after start is slave address
// - id 1010b selects memory array
// - id 1101b companion, memory latch untouched
// - address bits 2-1 match select pins
// - address bit 0: 1 read, 0 write
// - upper address bits beyond array ignored
// - memory latch advances each access, kept
// - reads start at current latched address
// - increment before ack, wrap to zero
// - companion takes one address byte, 00h-18h
// - companion address above 18h nacked, aborted
// - memory byte committed after 8th bit
// - companion address separate, auto-increments
module tws_slave #(
  parameter int MEM_AW = tws_pkg::MEM_AW_DEF
) (
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              link_clk_i,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  input  wire logic [1:0]        dev_sel_i,
  input  wire logic              supply_trip_threshold_i,
  output logic                   acc_valid_o,
  output tws_pkg::tws_acc_s      acc_o,
  input  wire logic [7:0]        acc_rdata_i
);
  import tws_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************
  // upper bits dropped
  function automatic logic [15:0] mem_mask(input logic [15:0] a);
    logic [15:0] m;
    m = 16'hffff >> (16 - MEM_AW);
    return a & m;
  endfunction

  function automatic logic [15:0] mem_inc(input logic [15:0] a);
    return mem_mask(16'(a + 16'h0001));
  endfunction

  function automatic logic [7:0] reg_inc(input logic [7:0] a);
    return (a >= REG_TOP) ? REG_ADDR_RST : 8'(a + 8'h01);
  endfunction

  function automatic logic addr_match(input logic [7:0] b, input logic [1:0] sel);
    return ((b[7:4] == MEM_ID) || (b[7:4] == REG_ID)) && (b[2:1] == sel);
  endfunction

  // ************************************************************
  // link domain reset and pin synchronisers
  // ************************************************************
  // async assert, release synchronised to the link clock
  logic      lrst_s1;
  logic      lrst_n;
  tws_pins_s pin_s1;
  tws_pins_s pin_s2;
  logic      prv_scl;
  logic      prv_sda;

  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lrst_s1 <= 1'b0;
      lrst_n  <= 1'b0;
    end else begin
      lrst_s1 <= 1'b1;
      lrst_n  <= lrst_s1;
    end
  end

  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      pin_s1  <= '{scl: 1'b1, sda: 1'b1, trip: 1'b0, sel: 2'h0};
      pin_s2  <= '{scl: 1'b1, sda: 1'b1, trip: 1'b0, sel: 2'h0};
      prv_scl <= 1'b1;
      prv_sda <= 1'b1;
    end else begin
      pin_s1  <= '{scl: scl_i, sda: sda_i, trip: supply_trip_threshold_i, sel: dev_sel_i};
      pin_s2  <= pin_s1;
      prv_scl <= pin_s2.scl;
      prv_sda <= pin_s2.sda;
    end
  end

  logic start;
  logic stop;
  logic rise;
  logic fall;

  assign start = pin_s2.scl & prv_scl & prv_sda & ~pin_s2.sda;
  assign stop  = pin_s2.scl & prv_scl & ~prv_sda & pin_s2.sda;
  assign rise  = pin_s2.scl & ~prv_scl;
  assign fall  = ~pin_s2.scl & prv_scl;

  // ************************************************************
  // link engine
  // ************************************************************
  tws_state_e  st;
  tws_state_e  next_st;
  tws_phase_e  ph;
  tws_phase_e  next_ph;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic [7:0]  shreg;
  logic [7:0]  next_shreg;
  logic [7:0]  hi;
  logic [7:0]  next_hi;
  logic [15:0] mem_addr;
  logic [15:0] next_mem_addr;
  logic [7:0]  reg_addr;
  logic [7:0]  next_reg_addr;
  logic        tgt_reg;
  logic        next_tgt_reg;
  logic        rw;
  logic        next_rw;
  logic        oe;
  logic        next_oe;
  logic        mack;
  logic        next_mack;
  logic        req_tog;
  logic        next_req_tog;
  tws_acc_s    acc_l;
  tws_acc_s    next_acc_l;
  logic [7:0]  rdata_l;
  logic [7:0]  rdata_c;
  logic [2:0]  ack_s;

  always_comb begin
    next_st       = st;
    next_ph       = ph;
    next_cnt      = cnt;
    next_shreg    = shreg;
    next_hi       = hi;
    next_mem_addr = mem_addr;
    next_reg_addr = reg_addr;
    next_tgt_reg  = tgt_reg;
    next_rw       = rw;
    next_oe       = oe;
    next_mack     = mack;
    next_req_tog  = req_tog;
    next_acc_l    = acc_l;
    // trip forces idle until a new start
    if (pin_s2.trip) begin
      next_st = ST_IDLE;
      next_oe = 1'b0;
    end else if (start) begin
      next_st  = ST_SLAVE;
      next_cnt = 4'h0;
      next_oe  = 1'b0;
    end else if (stop) begin
      next_st = ST_IDLE;
      next_oe = 1'b0;
    end else begin
      unique case (st)
        ST_IDLE: begin
        end
        ST_SLAVE, ST_RX: begin
          if (rise) begin
            next_shreg = {shreg[6:0], pin_s2.sda};
            next_cnt   = 4'(cnt + 4'h1);
          end else if (fall && cnt == BYTE_BITS) begin
            next_cnt = 4'h0;
            next_st  = ST_ACK_OUT;
            next_oe  = 1'b1;
            if (st == ST_SLAVE) begin
              if (!addr_match(shreg, pin_s2.sel)) begin
                next_st = ST_IDLE;
                next_oe = 1'b0;
              end else begin
                next_tgt_reg = (shreg[7:4] == REG_ID);
                next_rw      = shreg[0];
                next_ph      = (shreg[7:4] == REG_ID) ? PH_LO : PH_HI;
                if (shreg[0]) begin
                  next_req_tog = ~req_tog;
                  next_acc_l   = '{reg_tgt: (shreg[7:4] == REG_ID), write: 1'b0,
                                   addr: (shreg[7:4] == REG_ID) ? {8'h00, reg_addr} : mem_addr,
                                   wdata: 8'h00};
                end
              end
            end else begin
              unique case (ph)
                PH_HI: begin
                  next_hi = shreg;
                  next_ph = PH_LO;
                end
                PH_LO: begin
                  next_ph = PH_DATA;
                  if (tgt_reg) begin
                    if (shreg > REG_TOP) begin
                      next_st = ST_IDLE;
                      next_oe = 1'b0;
                    end else begin
                      next_reg_addr = shreg;
                    end
                  end else begin
                    next_mem_addr = mem_mask({hi, shreg});
                  end
                end
                default: begin
                  // commit after 8th bit, before ack
                  next_req_tog = ~req_tog;
                  next_acc_l   = '{reg_tgt: tgt_reg, write: 1'b1,
                                   addr: tgt_reg ? {8'h00, reg_addr} : mem_addr, wdata: shreg};
                  if (tgt_reg) begin
                    next_reg_addr = reg_inc(reg_addr);
                  end else begin
                    next_mem_addr = mem_inc(mem_addr);
                  end
                end
              endcase
            end
          end
        end
        ST_ACK_OUT: begin
          if (fall) begin
            next_cnt = 4'h0;
            if (rw) begin
              next_st    = ST_TX;
              next_shreg = rdata_l;
              next_oe    = ~rdata_l[7];
            end else begin
              next_st = ST_RX;
              next_oe = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (rise) begin
            next_cnt = 4'(cnt + 4'h1);
          end else if (fall) begin
            if (cnt == BYTE_BITS) begin
              next_st = ST_ACK_IN;
              next_oe = 1'b0;
              if (tgt_reg) begin
                next_reg_addr = reg_inc(reg_addr);
              end else begin
                next_mem_addr = mem_inc(mem_addr);
              end
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_oe    = ~shreg[6];
            end
          end
        end
        ST_ACK_IN: begin
          if (rise) begin
            next_mack = ~pin_s2.sda;
            if (!pin_s2.sda) begin
              next_req_tog = ~req_tog;
              next_acc_l   = '{reg_tgt: tgt_reg, write: 1'b0,
                               addr: tgt_reg ? {8'h00, reg_addr} : mem_addr, wdata: 8'h00};
            end
          end else if (fall) begin
            next_cnt = 4'h0;
            if (mack) begin
              next_st    = ST_TX;
              next_shreg = rdata_l;
              next_oe    = ~rdata_l[7];
            end else begin
              next_st = ST_IDLE;
            end
          end
        end
        default: begin
          next_st = ST_IDLE;
          next_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      st       <= ST_IDLE;
      ph       <= PH_HI;
      cnt      <= 4'h0;
      shreg    <= 8'h00;
      hi       <= 8'h00;
      mem_addr <= MEM_ADDR_RST;
      reg_addr <= REG_ADDR_RST;
      tgt_reg  <= 1'b0;
      rw       <= 1'b0;
      oe       <= 1'b0;
      mack     <= 1'b0;
      req_tog  <= 1'b0;
      acc_l    <= '0;
    end else begin
      st       <= next_st;
      ph       <= next_ph;
      cnt      <= next_cnt;
      shreg    <= next_shreg;
      hi       <= next_hi;
      mem_addr <= next_mem_addr;
      reg_addr <= next_reg_addr;
      tgt_reg  <= next_tgt_reg;
      rw       <= next_rw;
      oe       <= next_oe;
      mack     <= next_mack;
      req_tog  <= next_req_tog;
      acc_l    <= next_acc_l;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = oe;

  // ************************************************************
  // read data return into link domain
  // ************************************************************
  // rdata_c is held stable from its toggle until the next request
  logic [7:0] next_rdata_l;

  always_comb begin
    next_rdata_l = (ack_s[2] != ack_s[1]) ? rdata_c : rdata_l;
  end

  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      rdata_l <= 8'h00;
    end else begin
      rdata_l <= next_rdata_l;
    end
  end

  // ************************************************************
  // system clock side of the access handshake
  // ************************************************************
  logic [2:0] req_s;
  logic       ack_tog;
  logic       next_ack_tog;
  logic       next_valid;
  tws_acc_s   next_acc;
  logic [7:0] next_rdata_c;

  always_comb begin
    next_valid   = req_s[2] ^ req_s[1];
    next_acc     = next_valid ? acc_l : acc_o;
    next_rdata_c = acc_valid_o ? acc_rdata_i : rdata_c;
    next_ack_tog = ack_tog ^ acc_valid_o;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_s       <= 3'h0;
      acc_valid_o <= 1'b0;
      acc_o       <= '0;
      rdata_c     <= 8'h00;
      ack_tog     <= 1'b0;
    end else begin
      req_s       <= {req_s[1:0], req_tog};
      acc_valid_o <= next_valid;
      acc_o       <= next_acc;
      rdata_c     <= next_rdata_c;
      ack_tog     <= next_ack_tog;
    end
  end

  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      ack_s <= 3'h0;
    end else begin
      ack_s <= {ack_s[1:0], ack_tog};
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  logic quiet;
  assign quiet = !pin_s2.trip && !start && !stop;

  property p_start;
    @(posedge link_clk_i) disable iff (!lrst_n)
      (start && !pin_s2.trip) |=> (st == ST_SLAVE) && (cnt == 4'h0) && !sda_oe_o;
  endproperty
  a_start: assert property (p_start) else $error("start did not restart decoding");

  property p_stop;
    @(posedge link_clk_i) disable iff (!lrst_n)
      (stop && !pin_s2.trip) |=> (st == ST_IDLE) ##1 !sda_oe_o;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not abort");

  property p_trip;
    @(posedge link_clk_i) disable iff (!lrst_n)
      pin_s2.trip [*2] |=> (st == ST_IDLE) && !sda_oe_o;
  endproperty
  a_trip: assert property (p_trip) else $error("supply trip did not abort");

  property p_nack;
    @(posedge link_clk_i) disable iff (!lrst_n)
      (st == ST_ACK_IN && fall && !mack && quiet) |=> st == ST_IDLE;
  endproperty
  a_nack: assert property (p_nack) else $error("master nack did not end read");

  property p_nomatch;
    @(posedge link_clk_i) disable iff (!lrst_n)
      (st == ST_SLAVE && fall && cnt == BYTE_BITS && !addr_match(shreg, pin_s2.sel) && quiet)
        |=> !sda_oe_o throughout (st == ST_IDLE) [*4];
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("unselected slave drove the bus");

  property p_reg_range;
    @(posedge link_clk_i) disable iff (!lrst_n)
      (st == ST_RX && ph == PH_LO && tgt_reg && fall && cnt == BYTE_BITS && shreg > REG_TOP && quiet)
        |=> (st == ST_IDLE) && !sda_oe_o && $stable(reg_addr);
  endproperty
  a_reg_range: assert property (p_reg_range) else $error("bad companion address was acked");

  property p_mem_inc;
    @(posedge link_clk_i) disable iff (!lrst_n)
      (st == ST_RX && ph == PH_DATA && !tgt_reg && fall && cnt == BYTE_BITS && quiet)
        |=> (mem_addr == mem_inc($past(mem_addr))) && (req_tog != $past(req_tog)) && acc_l.write;
  endproperty
  a_mem_inc: assert property (p_mem_inc) else $error("memory write did not commit and advance");

  property p_reg_keep;
    @(posedge link_clk_i) disable iff (!lrst_n)
      (tgt_reg && st != ST_SLAVE && st != ST_IDLE) |=> $stable(mem_addr);
  endproperty
  a_reg_keep: assert property (p_reg_keep) else $error("companion access moved memory latch");

endmodule

// [tb/tws_master_model.sv]
module tws_master_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // bus idles high, clock stands still between frames
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic q();
    repeat (12) @(posedge clk_i);
    #1;
  endtask

  task automatic start();
    sda_low_o = 1'b0;
    q();
    scl_o = 1'b1;
    q();
    sda_low_o = 1'b1;
    q();
    scl_o = 1'b0;
    q();
  endtask

  task automatic stop();
    sda_low_o = 1'b1;
    q();
    scl_o = 1'b1;
    q();
    sda_low_o = 1'b0;
    q();
  endtask

  // stable while high
  // data changes a third of a bit after the fall, so sync skew never fakes a start
  task automatic bit_io(input logic b, output logic r);
    sda_low_o = ~b;
    q();
    scl_o = 1'b1;
    q();
    r = sda_i;
    scl_o = 1'b0;
    q();
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule

// [tb/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tws_pkg::*;

  localparam int AW = 8;
  localparam logic [15:0] MASK = 16'h00ff;
  localparam int LIMIT = 40000;

  logic clk_i;
  logic reset_n_i;
  logic link_clk_i;
  logic [1:0] sel;
  logic trip;
  logic [7:0] rdata;
  logic sda_o;
  logic sda_oe;
  logic acc_valid;
  tws_acc_s acc;
  logic scl;
  logic m_low;
  wire logic sda = ~(m_low | (sda_oe & ~sda_o));
  logic [7:0] arr [256];
  logic [7:0] regs [32];
  tws_acc_s exp_q [$];
  int fail_count;
  int tests_run;
  int cycles;
  logic [31:0] seed;
  logic [15:0] ptr;
  logic [7:0] rptr;

  tws_slave #(.MEM_AW(AW)) DUT (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .link_clk_i(link_clk_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .dev_sel_i(sel), .supply_trip_threshold_i(trip),
    .acc_valid_o(acc_valid), .acc_o(acc), .acc_rdata_i(rdata));

  tws_master_model m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

  always #4 clk_i = ~clk_i;

  // link clock free running, offset so edges never line up
  initial begin
    link_clk_i = 1'b0;
    #1.7;
    forever #3 link_clk_i = ~link_clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] sa(input logic [3:0] id, input logic rd);
    return {id, 1'b0, sel, rd};
  endfunction

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ************
  // access port: serve reads, compare against notes
  // ************
  always @(posedge clk_i) begin
    tws_acc_s e;
    #1;
    if (acc_valid === 1'b1) begin
      rdata = acc.reg_tgt ? regs[acc.addr[4:0]] : arr[acc.addr[7:0]];
      if (exp_q.size() == 0) begin
        check("acc_spurious", 32'h0, 32'h1);
      end else begin
        e = exp_q.pop_front();
        check("acc_kind", {e.reg_tgt, e.write, e.addr}, {acc.reg_tgt, acc.write, acc.addr});
        if (e.write) begin
          check("acc_wdata", e.wdata, acc.wdata);
        end
      end
    end
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      $display("BAD timeout expected done seen hang");
      tally_and_finish();
    end
  end

  task automatic wr(input logic [7:0] d, input logic ex);
    logic a;
    m.wr_byte(d, a);
    check("ack", {31'h0, ex}, {31'h0, a});
  endtask

  task automatic pick_sel();
    @(posedge clk_i);
    #1;
    seed = lfsr(seed);
    sel = seed[1:0];
  endtask

  task automatic mem_set(input logic [15:0] a);
    m.start();
    wr(sa(MEM_ID, 1'b0), 1'b1);
    wr(a[15:8], 1'b1);
    wr(a[7:0], 1'b1);
    ptr = a & MASK;
  endtask

  task automatic put(input logic tgt, input int n);
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      d = seed[7:0];
      if (tgt) begin
        regs[rptr[4:0]] = d;
        exp_q.push_back('{1'b1, 1'b1, {8'h00, rptr}, d});
        rptr = (rptr == REG_TOP) ? 8'h00 : rptr + 8'h01;
      end else begin
        arr[ptr[7:0]] = d;
        exp_q.push_back('{1'b0, 1'b1, ptr, d});
        ptr = (ptr + 16'h1) & MASK;
      end
      wr(d, 1'b1);
    end
  endtask

  task automatic rd(input logic tgt, input int n);
    logic [7:0] d;
    logic [7:0] a;
    m.start();
    // fetch leaves during the ack before its byte, so note it first
    exp_q.push_back('{tgt, 1'b0, tgt ? {8'h00, rptr} : ptr, 8'h00});
    wr(sa(tgt ? REG_ID : MEM_ID, 1'b1), 1'b1);
    for (int i = 0; i < n; i++) begin
      a = tgt ? rptr : ptr[7:0];
      if (tgt) begin
        rptr = (rptr == REG_TOP) ? 8'h00 : rptr + 8'h01;
      end else begin
        ptr = (ptr + 16'h1) & MASK;
      end
      if (i < n - 1) begin
        exp_q.push_back('{tgt, 1'b0, tgt ? {8'h00, rptr} : ptr, 8'h00});
      end
      m.rd_byte(i < n - 1, d);
      check("rdata", tgt ? regs[a[4:0]] : arr[a], d);
    end
  endtask

  task automatic endt(input string nm);
    repeat (40) @(posedge clk_i);
    check("left_over", 32'h0, exp_q.size());
    $display("test %s done", nm);
  endtask

  initial begin
    logic r;
    clk_i = 1'b0;
    reset_n_i = 1'b0;
    trip = 1'b0;
    sel = 2'b10;
    rdata = 8'h00;
    ptr = 16'h0;
    rptr = 8'h00;
    seed = 32'h24a89bc5;
    for (int i = 0; i < 256; i++) begin
      seed = lfsr(seed);
      arr[i] = seed[7:0];
      regs[i % 32] = seed[15:8];
    end
    repeat (4) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    repeat (20) @(posedge clk_i);
    pick_sel();
    mem_set(16'h12fe);
    put(1'b0, 3);
    m.stop();
    endt("write_wrap");
    pick_sel();
    mem_set(16'h00fe);
    rd(1'b0, 3);
    m.stop();
    rd(1'b0, 1);
    m.stop();
    endt("read_seq");
    pick_sel();
    m.start();
    wr(sa(REG_ID, 1'b0), 1'b1);
    wr(8'h17, 1'b1);
    rptr = 8'h17;
    put(1'b1, 2);
    m.stop();
    rd(1'b1, 1);
    m.stop();
    rd(1'b0, 1);
    m.stop();
    endt("companion");
    m.start();
    wr(sa(REG_ID, 1'b0), 1'b1);
    wr(8'h18, 1'b1);
    m.stop();
    m.start();
    wr(sa(REG_ID, 1'b0), 1'b1);
    wr(8'h19, 1'b0);
    m.stop();
    endt("reg_range");
    m.start();
    wr({MEM_ID, 1'b0, ~sel, 1'b0}, 1'b0);
    wr(8'h00, 1'b0);
    m.stop();
    m.start();
    wr(sa(4'h5, 1'b0), 1'b0);
    m.stop();
    endt("no_match");
    mem_set(16'h0040);
    for (int i = 0; i < 4; i++) begin
      m.bit_io(1'b1, r);
    end
    m.stop();
    mem_set(16'h0080);
    for (int i = 0; i < 5; i++) begin
      m.bit_io(1'b0, r);
    end
    rd(1'b0, 1);
    m.stop();
    endt("partial");
    mem_set(16'h0010);
    @(posedge clk_i);
    #1;
    trip = 1'b1;
    wr(8'h5a, 1'b0);
    @(posedge clk_i);
    #1;
    trip = 1'b0;
    m.stop();
    mem_set(16'h0020);
    put(1'b0, 1);
    m.stop();
    endt("supply_trip");
    tally_and_finish();
  end
endmodule
